// ### logic/sac_pkg.sv
package sac_pkg;
  // Register byte addresses (word index times four)
  localparam logic [3:0] ADDR_CTRL0 = 4'h0;
  localparam logic [3:0] ADDR_CTRL1 = 4'h4;
  localparam logic [3:0] ADDR_RES_HI = 4'h8;
  localparam logic [3:0] ADDR_RES_LO = 4'hC;
  localparam int ADDR_W = 4;
  // converter_control_zero fields
  localparam int C0_ON = 0;
  localparam int C0_GO = 1;
  localparam int C0_CHS_LO = 2;
  localparam int C0_CHS_HI = 6;
  // converter_control_one fields
  localparam int C1_PREF_LO = 0;
  localparam int C1_PREF_HI = 1;
  localparam int C1_CS_LO = 4;
  localparam int C1_CS_HI = 6;
  localparam int C1_FM = 7;
  // Fifth word: reference_control_register bits, done flag, irq enables, sleep
  localparam logic [4:0] ADDR_REF = 5'h10;
  localparam int RF_TEMP_RANGE_SELECT = 4;
  localparam int RF_TEMP_SENSE_ENABLE = 5;
  localparam int RF_FLAG = 8;
  localparam int RF_IE = 9;
  localparam int RF_PERIPHERAL_IRQ_ENABLE = 10;
  localparam int RF_GIE = 11;
  localparam int RF_SLEEP = 12;
  // Channel codes
  localparam logic [4:0] CH_TEMP = 5'h1D;
  localparam logic [4:0] CH_DAC = 5'h1E;
  localparam logic [4:0] CH_FVR = 5'h1F;
  localparam logic [4:0] CH_AN_MAX = 5'h03;
  // Positive reference codes
  localparam logic [1:0] PREF_VDD = 2'h0;
  localparam logic [1:0] PREF_EXT = 2'h2;
  localparam logic [1:0] PREF_FVR = 2'h3;
  // Conversion timing: 11.5 periods = 23 half periods
  localparam int RES_BITS = 10;
  localparam logic [4:0] HALF_PERIODS = 5'h17;
  localparam logic [1:0] RC_CODE = 2'h3;
  typedef enum logic [1:0] {SAC_IDLE, SAC_DELAY, SAC_CONV} sac_state_t;
endpackage

// ### logic/sac_top.sv
// Local design decisions: the Avalon-MM register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module sac_top #(
  parameter int INSTR_CYCLES = 4
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Avalon-MM slave
  input wire logic [sac_pkg::ADDR_W:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  // Dedicated RC oscillator, asynchronous
  input wire logic i_rc_clk,
  // Comparator answer from the analog core, asynchronous
  input wire logic i_cmp_high,
  // Analog controls
  output logic [6:0] o_mux_onehot,
  output logic [9:0] o_dac_trial,
  output logic o_sample,
  output logic [2:0] o_pref_onehot,
  output logic o_temp_power,
  output logic o_temp_four_drops,
  // System events
  output logic o_irq,
  output logic o_wake,
  output logic o_vector
);
  logic on;
  logic go;
  logic [4:0] channel_select_field;
  logic [1:0] pref;
  logic [2:0] cs;
  logic fm;
  logic temp_sense_enable;
  logic temp_range_select;
  logic flag;
  logic ie;
  logic peripheral_irq_enable;
  logic global_irq_enable;
  logic sleep;
  logic [7:0] res_hi;
  logic [7:0] res_lo;
  logic [9:0] sar;
  logic [9:0] trial;
  logic [4:0] half_cnt;
  logic [5:0] div_cnt;
  logic [7:0] dly_cnt;
  logic [1:0] rc_sync;
  logic rc_prev;
  logic [1:0] cmp_sync;
  logic ack;
  logic tick;
  logic done;
  logic use_rc;
  logic [6:0] div_max;
  logic wr_go;
  logic clr_go;
  logic wr_ref;
  logic [6:0] next_mux;
  sac_pkg::sac_state_t state;

  // Both x11 codes pick the RC clock; the top bit only doubles the system divider
  assign use_rc = cs[1:0] == sac_pkg::RC_CODE;
  assign wr_go = ack && i_write && i_address[sac_pkg::ADDR_W:0] == {1'b0, sac_pkg::ADDR_CTRL0}
    && i_writedata[sac_pkg::C0_GO] && on && i_writedata[sac_pkg::C0_ON];
  assign clr_go = ack && i_write && i_address == {1'b0, sac_pkg::ADDR_CTRL0} && !i_writedata[sac_pkg::C0_GO];
  assign wr_ref = ack && i_write && i_address == sac_pkg::ADDR_REF;
  // Bit-clock divider on the raw system clock: 2,8,32 then x2 when bit 2 set
  always_comb begin
    unique case (cs[1:0])
      2'h0: div_max = 7'h02;
      2'h1: div_max = 7'h08;
      2'h2: div_max = 7'h20;
      default: div_max = 7'h02;
    endcase
    if (cs[2]) begin
      div_max = div_max << 1;
    end
  end
  // Half-period ticks; RC edges count both ways so 11.5 periods is 23 ticks
  assign tick = use_rc ? (rc_sync[1] != rc_prev) : ({1'b0, div_cnt} == div_max[6:1] - 7'h01);
  // A bit decision needs three clocks of comparator latency (trial register and two sync stages),
  // so a two-clock bit period decides on stale answers; only full-scale levels convert true there
  assign done = state == sac_pkg::SAC_CONV && tick && half_cnt == sac_pkg::HALF_PERIODS - 5'h01;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rc_sync <= 2'h0;
      rc_prev <= 1'b0;
    end else begin
      rc_sync <= {rc_sync[0], i_rc_clk};
      rc_prev <= rc_sync[1];
    end
  end

  // Comparator answer is asynchronous to the system clock
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cmp_sync <= 2'h0;
    end else begin
      cmp_sync <= {cmp_sync[0], i_cmp_high};
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      div_cnt <= 6'h00;
    // Restarts on entry so the first bit decision waits a full bit period
    end else if (state != sac_pkg::SAC_CONV || tick) begin
      div_cnt <= 6'h00;
    end else begin
      div_cnt <= div_cnt + 6'h01;
    end
  end

  // Bus slave: one wait cycle, then ack
  // Writes land at the acknowledge edge, while the master still holds the request
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ack <= 1'b0;
      o_waitrequest <= 1'b1;
    end else begin
      ack <= (i_read || i_write) && !ack;
      o_waitrequest <= !((i_read || i_write) && !ack);
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      on <= 1'b0;
      channel_select_field <= 5'h00;
      pref <= sac_pkg::PREF_VDD;
      cs <= 3'h0;
      fm <= 1'b0;
      temp_sense_enable <= 1'b0;
      temp_range_select <= 1'b0;
      ie <= 1'b0;
      peripheral_irq_enable <= 1'b0;
      global_irq_enable <= 1'b0;
      sleep <= 1'b0;
    end else begin
      if (ack && i_write) begin
        unique case (i_address)
          {1'b0, sac_pkg::ADDR_CTRL0}: begin
            on <= i_writedata[sac_pkg::C0_ON];
            channel_select_field <= i_writedata[sac_pkg::C0_CHS_HI:sac_pkg::C0_CHS_LO];
          end
          {1'b0, sac_pkg::ADDR_CTRL1}: begin
            pref <= i_writedata[sac_pkg::C1_PREF_HI:sac_pkg::C1_PREF_LO];
            cs <= i_writedata[sac_pkg::C1_CS_HI:sac_pkg::C1_CS_LO];
            fm <= i_writedata[sac_pkg::C1_FM];
          end
          sac_pkg::ADDR_REF: begin
            temp_sense_enable <= i_writedata[sac_pkg::RF_TEMP_SENSE_ENABLE];
            temp_range_select <= i_writedata[sac_pkg::RF_TEMP_RANGE_SELECT];
            ie <= i_writedata[sac_pkg::RF_IE];
            peripheral_irq_enable <= i_writedata[sac_pkg::RF_PERIPHERAL_IRQ_ENABLE];
            global_irq_enable <= i_writedata[sac_pkg::RF_GIE];
            sleep <= i_writedata[sac_pkg::RF_SLEEP];
          end
          default: begin
          end
        endcase
      end
      if (o_wake) begin
        sleep <= 1'b0;
      end
    end
  end

  // Done flag: set wins over a software clear in the same cycle
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      flag <= 1'b0;
    end else if (done) begin
      flag <= 1'b1;
    end else if (wr_ref && !i_writedata[sac_pkg::RF_FLAG]) begin
      flag <= 1'b0;
    end
  end

  // Conversion sequencer
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= sac_pkg::SAC_IDLE;
      go <= 1'b0;
      half_cnt <= 5'h00;
      dly_cnt <= 8'h00;
      sar <= 10'h000;
      trial <= 10'h000;
      res_hi <= 8'h00;
      res_lo <= 8'h00;
    end else begin
      unique case (state)
        sac_pkg::SAC_IDLE: begin
          if (wr_go) begin
            go <= 1'b1;
            // Extra start delay lets the sleep request land before an RC conversion begins
            dly_cnt <= use_rc ? 8'(INSTR_CYCLES) : 8'h00;
            state <= sac_pkg::SAC_DELAY;
          end
        end
        sac_pkg::SAC_DELAY: begin
          if (dly_cnt != 8'h00) begin
            dly_cnt <= dly_cnt - 8'h01;
          end else begin
            half_cnt <= 5'h00;
            sar <= 10'h000;
            trial <= 10'h200;
            state <= sac_pkg::SAC_CONV;
          end
        end
        sac_pkg::SAC_CONV: begin
          if (tick) begin
            half_cnt <= half_cnt + 5'h01;
            // Odd ticks past the sample half decide one bit, MSB first
            if (half_cnt[0] && trial != 10'h000) begin
              if (!cmp_sync[1]) begin
                sar <= sar | trial;
              end
              trial <= trial >> 1;
            end
          end
          if (done) begin
            go <= 1'b0;
            state <= sac_pkg::SAC_IDLE;
            if (fm) begin
              res_hi <= {6'h00, sar[9:8]};
              res_lo <= sar[7:0];
            end else begin
              res_hi <= sar[9:2];
              res_lo <= {sar[1:0], 6'h00};
            end
          end
        end
        default: state <= sac_pkg::SAC_IDLE;
      endcase
      // Software abort or a sleep without the RC clock ends the conversion early
      // Undecided bits of a partial result read as zero
      if (state != sac_pkg::SAC_IDLE && !done && (clr_go || !on || (sleep && !use_rc))) begin
        go <= 1'b0;
        state <= sac_pkg::SAC_IDLE;
        if (state == sac_pkg::SAC_CONV) begin
          res_hi <= fm ? {6'h00, sar[9:8]} : sar[9:2];
          res_lo <= fm ? sar[7:0] : {sar[1:0], 6'h00};
        end
      end
    end
  end

  // Source select; a reserved code or a switched-off converter connects nothing
  always_comb begin
    next_mux = 7'h00;
    if (on) begin
      if (channel_select_field <= sac_pkg::CH_AN_MAX) begin
        next_mux[channel_select_field[1:0]] = 1'b1;
      end else if (channel_select_field == sac_pkg::CH_TEMP) begin
        next_mux[4] = 1'b1;
      end else if (channel_select_field == sac_pkg::CH_DAC) begin
        next_mux[5] = 1'b1;
      end else if (channel_select_field == sac_pkg::CH_FVR) begin
        next_mux[6] = 1'b1;
      end
    end
  end

  // Analog controls, all registered
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_mux_onehot <= 7'h00;
      o_dac_trial <= 10'h000;
      o_sample <= 1'b0;
      o_pref_onehot <= 3'h0;
      o_temp_power <= 1'b0;
      o_temp_four_drops <= 1'b0;
    end else begin
      o_mux_onehot <= next_mux;
      o_dac_trial <= sar | trial;
      o_sample <= on && state != sac_pkg::SAC_CONV;
      o_pref_onehot <= {pref == sac_pkg::PREF_FVR, pref == sac_pkg::PREF_EXT, pref == sac_pkg::PREF_VDD};
      o_temp_power <= temp_sense_enable;
      // Range select only reaches the indicator while it is powered
      o_temp_four_drops <= temp_sense_enable && temp_range_select;
    end
  end

  // System events
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_irq <= 1'b0;
      o_wake <= 1'b0;
      o_vector <= 1'b0;
    end else begin
      o_irq <= flag && ie;
      o_wake <= done && ie && sleep;
      o_vector <= flag && ie && peripheral_irq_enable && global_irq_enable;
    end
  end

  // Read data is loaded as the request is taken, so it already stands
  // at the edge where the master sees waitrequest low
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_readdata <= 32'h00000000;
    end else if (i_read && !ack) begin
      unique case (i_address)
        {1'b0, sac_pkg::ADDR_CTRL0}: o_readdata <= {25'h0, channel_select_field, go, on};
        {1'b0, sac_pkg::ADDR_CTRL1}: o_readdata <= {24'h0, fm, cs, 2'h0, pref};
        {1'b0, sac_pkg::ADDR_RES_HI}: o_readdata <= {24'h0, res_hi};
        {1'b0, sac_pkg::ADDR_RES_LO}: o_readdata <= {24'h0, res_lo};
        sac_pkg::ADDR_REF: o_readdata <= {19'h0, sleep, global_irq_enable, peripheral_irq_enable, ie, flag, 2'h0, temp_sense_enable, temp_range_select, 4'h0};
        default: o_readdata <= 32'h00000000;
      endcase
    end
  end
endmodule
`default_nettype wire

// ### tb/sac_analog_model.sv
`timescale 1ns/100ps
`default_nettype none
module sac_analog_model (
  // Level on the selected input
  input wire logic [9:0] i_level,
  // Controls from the converter
  input wire logic [9:0] i_dac_trial,
  input wire logic [6:0] i_mux_onehot,
  // Answers
  output logic o_cmp_high,
  output logic o_rc_clk
);
  // An unselected input floats low, so it always reads below the trial
  assign o_cmp_high = (i_mux_onehot == 7'h00) || (i_level < i_dac_trial);
  // The RC oscillator runs free, its edges always on falling edges of the system clock; 1.6 us bit period
  initial begin
    o_rc_clk = 1'b0;
    forever #800 o_rc_clk = ~o_rc_clk;
  end
endmodule
`default_nettype wire

// ### tb/sac_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module sac_asserts #(
  parameter int INSTR_CYCLES = 4
) (
  // Clock, reset and bus
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [sac_pkg::ADDR_W:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [31:0] o_readdata,
  input wire logic o_waitrequest,
  // Analog side
  input wire logic i_rc_clk,
  input wire logic i_cmp_high,
  input wire logic [6:0] o_mux_onehot,
  input wire logic [9:0] o_dac_trial,
  input wire logic o_sample,
  input wire logic [2:0] o_pref_onehot,
  input wire logic o_temp_power,
  input wire logic o_temp_four_drops,
  // Events
  input wire logic o_irq,
  input wire logic o_wake,
  input wire logic o_vector
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  bus_ack_a: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest)
    else $error("request not acknowledged in the next cycle");
  ack_pulse_a: assert property (!o_waitrequest |=> o_waitrequest)
    else $error("waitrequest low for more than one cycle");
  mux_onehot_a: assert property ($onehot0(o_mux_onehot))
    else $error("more than one input source connected");
  pref_onehot_a: assert property ($onehot0(o_pref_onehot))
    else $error("more than one positive reference routed");
  flag_hold_a: assert property ($fell(o_irq) |-> $past(i_write) || $past(i_write, 2))
    else $error("interrupt dropped without a software write");
  wake_pulse_a: assert property (o_wake |=> !o_wake)
    else $error("wake longer than one cycle");
  wake_irq_a: assert property (o_wake |-> ##[0:2] o_irq)
    else $error("wake without interrupt");
  vector_irq_a: assert property (o_vector |-> o_irq)
    else $error("vector without interrupt");
  trial_hold_a: assert property ($changed(o_dac_trial) |-> !o_sample || !$past(o_sample))
    else $error("trial code moved while sampling");
  conv_min_a: assert property ($fell(o_sample) |-> !o_sample [*8])
    else $error("conversion ended too early");
  conv_end_a: assert property ($fell(o_sample) |-> ##[20:1000] o_sample)
    else $error("conversion did not end in time");
  cover property (o_wake);
  cover property (o_vector);
  cover property ($rose(o_irq));
endmodule
bind sac_top sac_asserts #(.INSTR_CYCLES(INSTR_CYCLES)) i_asserts (.i_clk(i_clk), .i_rst(i_rst),
  .i_address(i_address), .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
  .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .i_rc_clk(i_rc_clk), .i_cmp_high(i_cmp_high),
  .o_mux_onehot(o_mux_onehot), .o_dac_trial(o_dac_trial), .o_sample(o_sample), .o_pref_onehot(o_pref_onehot),
  .o_temp_power(o_temp_power), .o_temp_four_drops(o_temp_four_drops), .o_irq(o_irq), .o_wake(o_wake),
  .o_vector(o_vector));
`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
module tb;
  logic i_clk, i_rst, rd, wr, cmp, rc, smp, tp, t4, irq, wake, vec, wq;
  logic [4:0] adr, c;
  logic [31:0] wd, rdata, q, seed;
  logic [9:0] level, trial;
  logic [15:0] e;
  logic [6:0] mux;
  logic [2:0] pref, code;
  int fail_count, num_checks;
  sac_top #(.INSTR_CYCLES(4)) i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_address(adr), .i_read(rd), .i_write(wr),
    .i_writedata(wd), .o_readdata(rdata), .o_waitrequest(wq), .i_rc_clk(rc), .i_cmp_high(cmp),
    .o_mux_onehot(mux), .o_dac_trial(trial), .o_sample(smp), .o_pref_onehot(pref), .o_temp_power(tp),
    .o_temp_four_drops(t4), .o_irq(irq), .o_wake(wake), .o_vector(vec));
  sac_analog_model i_model (.i_level(level), .i_dac_trial(trial), .i_mux_onehot(mux), .o_cmp_high(cmp),
    .o_rc_clk(rc));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [6:0] mux_exp(input logic [4:0] ch);
    return ch < 5'h04 ? 7'h01 << ch : ch >= 5'h1D ? 7'h10 << (ch - 5'h1D) : 7'h00;
  endfunction
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge i_clk);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    @(posedge i_clk iff wq === 1'b0);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic settle;
    repeat (2) @(negedge i_clk);
  endtask
  task automatic close_out;
    if (fail_count == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  initial begin
    repeat (40000) @(posedge i_clk);
    fail_count++;
    close_out;
  end
  initial begin
    {i_rst, adr, wd, rd, wr, level, seed, fail_count, num_checks} = '0;
    i_rst = 1'b1;
    seed = 32'h400E;
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    // Five registers, then one unmapped word
    for (int k = 0; k < 6; k++) begin
      bus(1'b0, 5'(k * 4), 32'h0);
      `CHK("reset read", 32'h0, q)
    end
    bus(1'b1, 5'h00, 32'h3);
    bus(1'b0, 5'h00, 32'h0);
    `CHK("go with turn on", 32'h1, q)
    for (int k = 0; k < 8; k++) begin
      c = k < 5 ? 5'(k) : 5'(k + 24);
      bus(1'b1, 5'h00, {25'h0, c, 2'b01});
      if (c == 5'h1D) repeat (8000) @(posedge i_clk);
      settle;
      `CHK("mux select", mux_exp(c), mux)
    end
    for (int k = 0; k < 3; k++) begin
      bus(1'b1, 5'h04, k == 0 ? 32'h0 : 32'(k + 1));
      settle;
      `CHK("reference", k == 0 ? 3'h1 : k == 1 ? 3'h2 : 3'h4, pref)
    end
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, 5'h10, {26'h0, 2'(k), 4'h0});
      settle;
      `CHK("temp power", k[1], tp)
      `CHK("four drops", k[1] && k[0], t4)
    end
    // Pass 8 converts in sleep on the RC clock
    for (int cs = 0; cs < 9; cs++) begin
      seed = lfsr(seed);
      // Two-clock bit periods decide on stale answers; full scale converts true anyway
      level <= cs == 0 ? 10'h3FF : cs == 7 ? 10'h000 : seed[9:0];
      code = cs == 8 ? 3'h3 : 3'(cs);
      bus(1'b1, 5'h10, cs == 8 ? 32'h1200 : 32'h0);
      bus(1'b1, 5'h04, {24'h0, seed[10], code, 4'h0});
      bus(1'b1, 5'h00, {27'h0, 1'b0, 2'(cs), 2'b01});
      repeat (20) @(posedge i_clk);
      bus(1'b1, 5'h00, {27'h0, 1'b0, 2'(cs), 2'b11});
      if (cs == 8) begin
        @(posedge i_clk iff wake === 1'b1);
      end
      else begin
        do bus(1'b0, 5'h00, 32'h0); while (q[1] !== 1'b0);
      end
      e = seed[10] ? {6'h00, level} : {level, 6'h00};
      bus(1'b0, 5'h08, 32'h0);
      `CHK("result high", {24'h0, e[15:8]}, q)
      bus(1'b0, 5'h0C, 32'h0);
      `CHK("result low", {24'h0, e[7:0]}, q)
      bus(1'b0, 5'h10, 32'h0);
      `CHK("status", cs == 8 ? 32'h300 : 32'h100, q)
      `CHK("irq", cs == 8, irq)
      if (cs == 8) begin
        bus(1'b1, 5'h10, 32'hF00);
        settle;
        `CHK("vector", 1'b1, vec)
      end
      bus(1'b1, 5'h10, cs == 8 ? 32'hE00 : 32'h0);
      settle;
      `CHK("irq cleared", 1'b0, irq)
    end
    close_out;
  end
endmodule
`default_nettype wire
